// file: rtl/eag_core.sv
/*
  Effective address generator: branch targets and operand addresses.
  Assumes the core holds op_valid for one cycle per instruction, keeps the
  register file outside, and answers table reads with mem_rdata in the same
  cycle as mem_rd_r.
*/
`timescale 1ns/1ps
`default_nettype none
module eag_core
  import eag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire logic [3:0] op_mode,
  input wire logic [7:0] op_code,
  input wire logic [15:0] op_imm16,
  input wire logic [7:0] op_imm8,
  input wire logic op_word,
  input wire logic op_use_base,
  input wire logic [15:0] acc_pair,
  input wire logic [15:0] count_pair,
  input wire logic [15:0] second_pointer_pair,
  input wire logic [15:0] base_pair,
  input wire logic [15:0] stack_ptr,
  input wire logic [7:0] mem_rdata,
  output logic pc_load_r,
  output logic [15:0] pc_target_r,
  output logic addr_valid_r,
  output logic [15:0] addr_r,
  output logic addr_is_ram_r,
  output logic addr_is_sfr_r,
  output logic addr_err_r,
  output logic reg_sel_valid_r,
  output logic reg_sel_word_r,
  output logic [2:0] reg_sel_r,
  output logic mem_rd_r,
  output logic [15:0] mem_raddr_r,
  output logic busy_r
);
  // =====================================================
  // State
  typedef struct packed {
    eag_state_t st;
    logic busy;
    logic [15:0] vec;
    logic [7:0] lo;
    logic pc_load;
    logic [15:0] pc;
    logic av;
    logic [15:0] addr;
    logic ram;
    logic sfr;
    logic err;
    logic rv;
    logic rw;
    logic [2:0] rs;
    logic rd;
    logic [15:0] raddr;
  } eag_reg_t;

  eag_reg_t s_r, s_nxt;
  eag_mode_t mode;
  assign mode = eag_mode_t'(op_mode);

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= EAG_SADDR_LO) && (a <= EAG_RAM_HI);
  endfunction

  function automatic logic in_sfr(input logic [15:0] a);
    in_sfr = (a >= EAG_SFR_LO) && !((a >= EAG_SFR_GAP_LO) && (a <= EAG_SFR_GAP_HI));
  endfunction

  // =====================================================
  // Next state
  always_comb begin
    logic [15:0] a;
    a = EAG_RESET_ADDR;
    s_nxt = s_r;
    s_nxt.pc_load = 1'b0;
    s_nxt.av = 1'b0;
    s_nxt.rv = 1'b0;
    s_nxt.rd = 1'b0;
    unique case (s_r.st)
      EAG_S_IDLE: begin
        if (op_valid) begin
          unique case (mode)
            EAG_M_IMM_BR: begin
              s_nxt.pc_load = 1'b1;
              s_nxt.pc = op_imm16;
            end
            EAG_M_TABLE: begin
              // Each entry is two bytes, low byte first
              s_nxt.vec = EAG_TABLE_BASE |
                {10'h000, op_code[EAG_VEC_MSB:EAG_VEC_LSB], 1'b0};
              s_nxt.rd = 1'b1;
              s_nxt.raddr = s_nxt.vec;
              s_nxt.st = EAG_S_TLO;
              s_nxt.busy = 1'b1;
            end
            EAG_M_REG_BR: begin
              s_nxt.pc_load = 1'b1;
              s_nxt.pc = acc_pair;
            end
            EAG_M_REG: begin
              s_nxt.rv = 1'b1;
              s_nxt.rw = op_word;
              // Code order follows the pair and byte layout directly
              s_nxt.rs = op_word ? {1'b0, op_code[1:0]} : op_code[2:0];
            end
            EAG_M_NONE: begin
            end
            default: begin
              unique case (mode)
                EAG_M_DIRECT: a = op_imm16;
                EAG_M_SHORT: a = eag_short_addr(op_imm8);
                EAG_M_SFR: a = {EAG_UPPER_SFR, op_imm8};
                EAG_M_INDIRECT: a = op_use_base ? base_pair : second_pointer_pair;
                EAG_M_BASED: a = base_pair + {8'h00, op_imm8};
                EAG_M_STACK: a = stack_ptr;
                default: a = EAG_RESET_ADDR;
              endcase
              s_nxt.av = 1'b1;
              s_nxt.addr = a;
              s_nxt.ram = in_ram(a);
              s_nxt.sfr = in_sfr(a);
              // Flags an illegal target: stack outside RAM, SFR in the gap, odd word in short mode, undefined mode
              s_nxt.err = ((mode == EAG_M_STACK) && !in_ram(a)) ||
                          ((mode == EAG_M_SFR) && !in_sfr(a)) ||
                          ((mode == EAG_M_SHORT) && op_word && a[0]) ||
                          (eag_mode_t'(op_mode) > EAG_M_STACK);
            end
          endcase
        end
      end
      EAG_S_TLO: begin
        s_nxt.lo = mem_rdata;
        s_nxt.rd = 1'b1;
        s_nxt.raddr = s_r.vec + 16'h0001;
        s_nxt.st = EAG_S_THI;
      end
      EAG_S_THI: begin
        s_nxt.pc_load = 1'b1;
        s_nxt.pc = {mem_rdata, s_r.lo};
        s_nxt.st = EAG_S_IDLE;
        s_nxt.busy = 1'b0;
      end
      default: begin
        s_nxt.st = EAG_S_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // =====================================================
  // Outputs
  assign pc_load_r = s_r.pc_load;
  assign pc_target_r = s_r.pc;
  assign addr_valid_r = s_r.av;
  assign addr_r = s_r.addr;
  assign addr_is_ram_r = s_r.ram;
  assign addr_is_sfr_r = s_r.sfr;
  assign addr_err_r = s_r.err;
  assign reg_sel_valid_r = s_r.rv;
  assign reg_sel_word_r = s_r.rw;
  assign reg_sel_r = s_r.rs;
  assign mem_rd_r = s_r.rd;
  assign mem_raddr_r = s_r.raddr;
  assign busy_r = s_r.busy;

  // =====================================================
  // Checks
  sequence imm_req_s;
    op_valid && clk_en && !busy_r && (op_mode == 4'h1);
  endsequence

  imm_branch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    imm_req_s |=> (pc_load_r && pc_target_r == $past(op_imm16)))
    else $error("immediate branch target wrong");

  reg_branch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op_valid && clk_en && !busy_r && op_mode == 4'h3) |=>
    (pc_load_r && pc_target_r == $past(acc_pair)))
    else $error("register branch target wrong");

  // Table fetch steps: request, low byte read, high byte read
  sequence tbl_req_s;
    op_valid && clk_en && !busy_r && (op_mode == 4'h2);
  endsequence

  sequence tbl_lo_s;
    mem_rd_r && busy_r && !mem_raddr_r[0] && clk_en;
  endsequence

  sequence tbl_hi_s;
    mem_rd_r && busy_r && mem_raddr_r[0] && clk_en;
  endsequence

  table_fetch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tbl_req_s |=>
    (mem_rd_r && busy_r && mem_raddr_r >= 16'h0040 && mem_raddr_r <= 16'h007e &&
     !mem_raddr_r[0]))
    else $error("table entry address out of range");

  table_next_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tbl_lo_s |=>
    (mem_rd_r && busy_r && mem_raddr_r == 16'($past(mem_raddr_r) + 16'h0001)))
    else $error("table high byte address wrong");

  table_load_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tbl_hi_s |=> (pc_load_r && !busy_r && pc_target_r[15:8] == $past(mem_rdata)))
    else $error("table target not loaded");

  direct_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op_valid && clk_en && !busy_r && op_mode == 4'h4) |=> (addr_r == $past(op_imm16)))
    else $error("direct address altered");

  short_window_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op_valid && clk_en && !busy_r && op_mode == 4'h5) |=>
    (addr_r >= 16'hfe20 && addr_r <= 16'hff1f && addr_r[7:0] == $past(op_imm8)))
    else $error("short direct address outside window");

  short_bit8_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op_valid && clk_en && !busy_r && op_mode == 4'h5) |=>
    (addr_r[8] == ($past(op_imm8) < 8'h20)))
    else $error("short direct bit 8 wrong");

  sfr_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op_valid && clk_en && !busy_r && op_mode == 4'h6) |=>
    (addr_r == {8'hff, $past(op_imm8)}))
    else $error("special register address wrong");

  based_sum_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op_valid && clk_en && !busy_r && op_mode == 4'h9) |=>
    (addr_r == 16'($past(base_pair) + {8'h00, $past(op_imm8)})))
    else $error("based address sum wrong");

  stack_ram_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op_valid && clk_en && !busy_r && op_mode == 4'ha) |=>
    (addr_r == $past(stack_ptr) && addr_is_ram_r == !addr_err_r &&
     addr_err_r != (addr_r >= 16'hfe20 && addr_r <= 16'hfeff)))
    else $error("stack access outside high-speed ram not flagged");
endmodule // eag_core
`default_nettype wire

// file: rtl/eag_pkg.sv
/*
  Constants, modes and helpers for the effective address generator.
  Assumes a core that presents decoded instruction fields and register contents.
*/
package eag_pkg;
  // =====================================================
  // Address map
  localparam logic [15:0] EAG_SADDR_LO = 16'hfe20;
  localparam logic [15:0] EAG_SADDR_HI = 16'hff1f;
  localparam logic [15:0] EAG_RAM_HI = 16'hfeff;
  localparam logic [15:0] EAG_SFR_LO = 16'hff00;
  localparam logic [15:0] EAG_SFR_GAP_LO = 16'hffd0;
  localparam logic [15:0] EAG_SFR_GAP_HI = 16'hffdf;
  localparam logic [7:0] EAG_SADDR_SPLIT = 8'h20;
  localparam logic [7:0] EAG_UPPER_SFR = 8'hff;
  localparam logic [7:0] EAG_UPPER_RAM = 8'hfe;
  localparam logic [15:0] EAG_TABLE_BASE = 16'h0040;
  localparam int EAG_VEC_LSB = 1;
  localparam int EAG_VEC_MSB = 5;
  localparam logic [15:0] EAG_RESET_ADDR = 16'h0000;

  // =====================================================
  // Modes
  typedef enum logic [3:0] {
    EAG_M_NONE = 4'h0, EAG_M_IMM_BR = 4'h1, EAG_M_TABLE = 4'h2, EAG_M_REG_BR = 4'h3,
    EAG_M_DIRECT = 4'h4, EAG_M_SHORT = 4'h5, EAG_M_SFR = 4'h6, EAG_M_REG = 4'h7,
    EAG_M_INDIRECT = 4'h8, EAG_M_BASED = 4'h9, EAG_M_STACK = 4'ha
  } eag_mode_t;

  // Table fetch sequence: Gray along idle, low byte, high byte
  typedef enum logic [1:0] {
    EAG_S_IDLE = 2'b00, EAG_S_TLO = 2'b01, EAG_S_THI = 2'b11
  } eag_state_t;

  // Byte register codes X,A,C,B,E,D,L,H = 0..7; pairs acc,count,second,base = 0..3
  localparam logic [1:0] EAG_RP_ACC = 2'h0;
  localparam logic [1:0] EAG_RP_SECOND = 2'h2;
  localparam logic [1:0] EAG_RP_BASE = 2'h3;

  function automatic logic [15:0] eag_short_addr(input logic [7:0] f);
    eag_short_addr = {(f < EAG_SADDR_SPLIT) ? EAG_UPPER_SFR : EAG_UPPER_RAM, f};
  endfunction
endpackage : eag_pkg

// file: tb/eag_mem_model.sv
/*
  Table memory seen by the address generator's fetch port.
  Assumes the design samples a byte on each edge that follows a cycle with mem_rd_r high.
*/
`timescale 1ns/1ps
`default_nettype none
module eag_mem_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic mem_rd_r,
  input wire logic [15:0] mem_raddr_r,
  output logic [7:0] mem_rdata
);
  logic [7:0] idle_r;
  // ==========================================
  // Entry byte is a fixed scramble of its address
  assign mem_rdata = mem_rd_r ? (mem_raddr_r[7:0] ^ 8'h5a) : idle_r;
  // Off-read value flips every cycle so stale data never looks valid
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) idle_r <= 8'h00;
    else idle_r <= ~mem_rdata;
  end
endmodule // eag_mem_model
`default_nettype wire

// file: tb/effective_address_generator_tb.sv
/*
  Self-checking bench for eag_core with the table memory model.
  Assumes eag_pkg mode encodings and the one-request-per-answer contract.
*/
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator_tb;
  import eag_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic op_valid = 1'b0;
  logic [3:0] op_mode = 4'h0;
  logic [7:0] op_code = 8'h00;
  logic [15:0] op_imm16 = 16'h0000;
  logic [7:0] op_imm8 = 8'h00;
  logic op_word = 1'b0;
  logic op_use_base = 1'b0;
  logic [15:0] acc_pair = 16'h1234;
  logic [15:0] count_pair = 16'h5566;
  logic [15:0] second_pointer_pair = 16'hbeef;
  logic [15:0] base_pair = 16'hfff0;
  logic [15:0] stack_ptr = 16'hfe80;
  logic [7:0] mem_rdata;
  logic pc_load_r, addr_valid_r, addr_is_ram_r, addr_is_sfr_r, addr_err_r;
  logic reg_sel_valid_r, reg_sel_word_r, mem_rd_r, busy_r;
  logic [15:0] pc_target_r, addr_r, mem_raddr_r;
  logic [2:0] reg_sel_r;
  int fail_count = 0;
  int tests_run = 0;

  eag_core uut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .op_valid(op_valid),
    .op_mode(op_mode), .op_code(op_code), .op_imm16(op_imm16), .op_imm8(op_imm8),
    .op_word(op_word), .op_use_base(op_use_base), .acc_pair(acc_pair),
    .count_pair(count_pair), .second_pointer_pair(second_pointer_pair),
    .base_pair(base_pair), .stack_ptr(stack_ptr), .mem_rdata(mem_rdata),
    .pc_load_r(pc_load_r), .pc_target_r(pc_target_r), .addr_valid_r(addr_valid_r),
    .addr_r(addr_r), .addr_is_ram_r(addr_is_ram_r), .addr_is_sfr_r(addr_is_sfr_r),
    .addr_err_r(addr_err_r), .reg_sel_valid_r(reg_sel_valid_r),
    .reg_sel_word_r(reg_sel_word_r), .reg_sel_r(reg_sel_r), .mem_rd_r(mem_rd_r),
    .mem_raddr_r(mem_raddr_r), .busy_r(busy_r));
  eag_mem_model mem (.clk_sys(clk_sys), .rst_b(rst_b), .mem_rd_r(mem_rd_r),
    .mem_raddr_r(mem_raddr_r), .mem_rdata(mem_rdata));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ==========================================
  // Shared checks and driver
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One request, then wait for the answer pulse; latency in cycles after the taking edge
  task automatic op(input logic [3:0] m, input logic [7:0] c, input logic [15:0] i16,
                    input logic [7:0] i8, input logic w, input logic b, input int lat);
    int n;
    n = 0;
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_mode <= m;
    op_code <= c;
    op_imm16 <= i16;
    op_imm8 <= i8;
    op_word <= w;
    op_use_base <= b;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (!(pc_load_r === 1'b1 || addr_valid_r === 1'b1 || reg_sel_valid_r === 1'b1)
               && n < 20);
    check(n, lat);
  endtask

  task automatic chk_addr(input logic [15:0] a, input logic ram, input logic sfr,
                          input logic err);
    check({addr_valid_r, addr_r, addr_is_ram_r, addr_is_sfr_r, addr_err_r},
          {1'b1, a, ram, sfr, err});
  endtask

  // ==========================================
  // Scenarios
  task automatic sc_branch;
    op(EAG_M_IMM_BR, 8'h00, 16'hfffe, 8'h00, 1'b0, 1'b0, 1);
    check(pc_target_r, 16'hfffe);
    op(EAG_M_TABLE, 8'hff, 16'h0000, 8'h00, 1'b0, 1'b0, 3);
    check(pc_target_r, 16'h2524);
    op(EAG_M_TABLE, 8'hc0, 16'h0000, 8'h00, 1'b0, 1'b0, 3);
    check(pc_target_r, 16'h1b1a);
    op(EAG_M_REG_BR, 8'h00, 16'h0000, 8'h00, 1'b0, 1'b0, 1);
    check(pc_target_r, 16'h1234);
  endtask

  task automatic sc_operand;
    op(EAG_M_DIRECT, 8'h00, 16'hfe00, 8'h00, 1'b0, 1'b0, 1);
    chk_addr(16'hfe00, 0, 0, 0);
    op(EAG_M_SHORT, 8'h00, 16'h0000, 8'h1f, 1'b0, 1'b0, 1);
    chk_addr(16'hff1f, 0, 1, 0);
    op(EAG_M_SHORT, 8'h00, 16'h0000, 8'h20, 1'b0, 1'b0, 1);
    chk_addr(16'hfe20, 1, 0, 0);
    op(EAG_M_SHORT, 8'h00, 16'h0000, 8'hff, 1'b0, 1'b0, 1);
    chk_addr(16'hfeff, 1, 0, 0);
    op(EAG_M_SHORT, 8'h00, 16'h0000, 8'h00, 1'b0, 1'b0, 1);
    chk_addr(16'hff00, 0, 1, 0);
    op(EAG_M_SFR, 8'h00, 16'h0000, 8'h00, 1'b0, 1'b0, 1);
    chk_addr(16'hff00, 0, 1, 0);
    op(EAG_M_SFR, 8'h00, 16'h0000, 8'hff, 1'b0, 1'b0, 1);
    chk_addr(16'hffff, 0, 1, 0);
    op(EAG_M_SFR, 8'h00, 16'h0000, 8'hcf, 1'b0, 1'b0, 1);
    chk_addr(16'hffcf, 0, 1, 0);
    op(EAG_M_SFR, 8'h00, 16'h0000, 8'hd0, 1'b0, 1'b0, 1);
    chk_addr(16'hffd0, 0, 0, 1);
    // Word operand at an even short address, as software must give
    op(EAG_M_SHORT, 8'h00, 16'h0000, 8'h22, 1'b1, 1'b0, 1);
    chk_addr(16'hfe22, 1, 0, 0);
    op(EAG_M_SHORT, 8'h00, 16'h0000, 8'h21, 1'b1, 1'b0, 1);
    check(addr_err_r, 1'b1);
    op(EAG_M_INDIRECT, 8'h00, 16'h0000, 8'h00, 1'b0, 1'b0, 1);
    check(addr_r, 16'hbeef);
    op(EAG_M_INDIRECT, 8'h00, 16'h0000, 8'h00, 1'b0, 1'b1, 1);
    check(addr_r, 16'hfff0);
    op(EAG_M_BASED, 8'h00, 16'h0000, 8'h25, 1'b0, 1'b0, 1);
    check(addr_r, 16'h0015);
  endtask

  task automatic sc_stack_regs;
    op(EAG_M_STACK, 8'h00, 16'h0000, 8'h00, 1'b0, 1'b0, 1);
    chk_addr(16'hfe80, 1, 0, 0);
    @(posedge clk_sys);
    stack_ptr <= 16'hff00;
    op(EAG_M_STACK, 8'h00, 16'h0000, 8'h00, 1'b0, 1'b0, 1);
    check(addr_err_r, 1'b1);
    for (int k = 0; k < 8; k++) begin
      op(EAG_M_REG, {5'h1a, 3'(k)}, 16'h0000, 8'h00, 1'b0, 1'b0, 1);
      check({reg_sel_valid_r, reg_sel_word_r, reg_sel_r}, {2'b10, 3'(k)});
    end
    for (int k = 0; k < 4; k++) begin
      op(EAG_M_REG, {6'h2d, 2'(k)}, 16'h0000, 8'h00, 1'b1, 1'b0, 1);
      check({reg_sel_word_r, reg_sel_r}, {2'b10, 2'(k)});
    end
  endtask

  // Table fetch stalled by clock enable; a branch raised while busy must be ignored
  task automatic sc_freeze;
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_mode <= EAG_M_TABLE;
    op_code <= 8'h06;
    @(posedge clk_sys);
    op_mode <= EAG_M_IMM_BR;
    op_imm16 <= 16'h4321;
    clk_en <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({mem_rd_r, busy_r, mem_raddr_r}, {2'b11, 16'h0046});
    @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    op_valid <= 1'b0;
    @(negedge clk_sys);
    check({pc_load_r, busy_r, pc_target_r}, {2'b10, 16'h1d1c});
    @(negedge clk_sys);
    check({pc_load_r, addr_valid_r, pc_target_r}, {2'b00, 16'h1d1c});
  endtask

  // Reset in the middle of a table fetch abandons it; the next request still works
  task automatic sc_mid_reset;
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_mode <= EAG_M_TABLE;
    op_code <= 8'h3e;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(negedge clk_sys);
    check({pc_load_r, mem_rd_r, busy_r, pc_target_r}, 19'h00000);
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    check({pc_load_r, mem_rd_r, busy_r, mem_raddr_r}, 19'h00000);
    op(EAG_M_DIRECT, 8'h00, 16'h1357, 8'h00, 1'b0, 1'b0, 1);
    chk_addr(16'h1357, 0, 0, 0);
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    check({pc_load_r, addr_valid_r, reg_sel_valid_r, mem_rd_r, busy_r}, 5'h00);
    sc_branch;
    sc_operand;
    sc_stack_regs;
    sc_freeze;
    sc_mid_reset;
    end_sim;
  end

  initial begin
    #20000;
    fail_count++;
    end_sim;
  end
endmodule // effective_address_generator_tb
`default_nettype wire
